// [hdl/ssmc_spi_shifter.sv]
// serial slave shifter sampled by the system clock
`timescale 1ns/1ps
`include "ssmc_defines.svh"
module ssmc_spi_shifter (
    input  wire logic      i_sys_clk,
    input  wire logic      i_rst_n,
    input  wire logic      i_ce,
    input  wire logic      i_cs_n,
    input  wire logic      i_sclk,
    input  wire logic      i_si,
    ssmc_spi_if.shifter    bus
);

    ssmc_pkg::ssmc_shift_s r_reg;
    ssmc_pkg::ssmc_shift_s r_next;

    logic cs_n;
    logic sclk;
    logic sclk_rise;
    logic sclk_fall;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_next         = r_reg;
        r_next.cs_s    = {r_reg.cs_s[0], i_cs_n};
        r_next.sclk_s  = {r_reg.sclk_s[0], i_sclk};
        r_next.si_s    = {r_reg.si_s[0], i_si};
        cs_n           = r_reg.cs_s[1];
        sclk           = r_reg.sclk_s[1];
        r_next.cs_d    = cs_n;
        r_next.sclk_d  = sclk;
        sclk_rise      = sclk & ~r_reg.sclk_d;
        sclk_fall      = ~sclk & r_reg.sclk_d;
        r_next.cs_rise = cs_n & ~r_reg.cs_d;
        r_next.cs_fall = ~cs_n & r_reg.cs_d;
        if (cs_n) begin
            r_next.so_oe = 1'b0;
            r_next.so    = 1'b0;
        end else if (r_reg.cs_d) begin
            r_next.so_oe = 1'b1;
            r_next.tx    = bus.tx_word;
            r_next.so    = bus.tx_word[`SSMC_WORD_W-1];
        end else begin
            if (sclk_rise) begin
                r_next.tx = {r_reg.tx[`SSMC_WORD_W-2:0], 1'b0};
                r_next.so = r_reg.tx[`SSMC_WORD_W-2];
            end
            if (sclk_fall) begin
                r_next.rx = {r_reg.rx[`SSMC_WORD_W-2:0], r_reg.si_s[1]};
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r_reg <= '0;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    assign bus.cs_rise = r_reg.cs_rise;
    assign bus.cs_fall = r_reg.cs_fall;
    assign bus.rx_word = r_reg.rx;
    assign bus.so      = r_reg.so;
    assign bus.so_oe   = r_reg.so_oe;

endmodule : ssmc_spi_shifter

// [hdl/ssmc_top.sv]
// mode controller with serial command port for a four-output power switch
`timescale 1ns/1ps
`include "ssmc_defines.svh"
module ssmc_top #(
    parameter logic [31:0] WD_BASE_CYC = 32'(`SSMC_WDTO0_CYC)
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_ce,
    input  wire logic       i_cs_n,
    input  wire logic       i_sclk,
    input  wire logic       i_si,
    input  wire logic       i_wake,
    input  wire logic       i_reset_pin_n,
    input  wire logic [1:0] i_failsafe_select_input,
    input  wire logic [3:0] i_fault_cond,
    output logic            o_so,
    output logic            o_so_oe,
    output logic            o_fault_flag_n_o,
    output logic            o_fault_flag_n_oe,
    output logic [3:0]      o_power_output,
    output logic [1:0]      o_mode,
    output logic            o_watchdog_expired
);

    ////////////////////////////////////////////////////////////////////////////
    // serial shifter

    ssmc_spi_if bus ();

    ssmc_spi_shifter u_shifter (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_ce      (i_ce),
        .i_cs_n    (i_cs_n),
        .i_sclk    (i_sclk),
        .i_si      (i_si),
        .bus       (bus.shifter)
    );

    ////////////////////////////////////////////////////////////////////////////
    // state

    ssmc_pkg::ssmc_ctrl_s r_reg;
    ssmc_pkg::ssmc_ctrl_s r_next;

    logic        wake;
    logic        rstp;
    logic [1:0]  failsafe_select_input;
    logic [3:0]  fault_now;
    logic        fsi_gnd;
    logic        rst_rise;
    logic        wake_rise;
    logic        both_fall;
    logic [4:0]  cmd_addr;
    logic [7:0]  cmd_data;
    logic        cmd_ka;
    logic [31:0] wd_limit;
    logic [3:0]  fs_pattern;

    ////////////////////////////////////////////////////////////////////////////
    // mode selection outside fail-safe

    function automatic ssmc_pkg::ssmc_mode_e pick_mode(
        input logic       f_wake,
        input logic       f_rstp,
        input logic       f_exp,
        input logic [3:0] f_fault
    );
        ssmc_pkg::ssmc_mode_e m;
        if (!f_wake && !f_rstp) begin
            m = ssmc_pkg::SSMC_SLEEP;
        end else if (f_exp) begin
            m = ssmc_pkg::SSMC_FAILSAFE;
        end else if (|f_fault) begin
            m = ssmc_pkg::SSMC_FAULT;
        end else begin
            m = ssmc_pkg::SSMC_NORMAL;
        end
        return m;
    endfunction : pick_mode

    ////////////////////////////////////////////////////////////////////////////
    // status word

    always_comb begin
        bus.tx_word = {
            r_reg.fault_lat,
            r_reg.power_out,
            r_reg.fsi_s1,
            r_reg.wake_s[1],
            r_reg.rstp_s[1],
            r_reg.wd_run,
            (r_reg.mode == ssmc_pkg::SSMC_FAILSAFE),
            r_reg.wd_sel
        };
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog period

    always_comb begin
        unique case (r_reg.wd_sel)
            `SSMC_WD_SEL_BASE:   wd_limit = WD_BASE_CYC;
            `SSMC_WD_SEL_HALF:   wd_limit = {1'b0, WD_BASE_CYC[31:1]};
            `SSMC_WD_SEL_QUAD:   wd_limit = {WD_BASE_CYC[29:0], 2'b00};
            `SSMC_WD_SEL_DOUBLE: wd_limit = {WD_BASE_CYC[30:0], 1'b0};
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // fail-safe output pattern

    always_comb begin
        unique case (r_reg.fsi_s1)
            `SSMC_FSI_GROUNDED: fs_pattern = `SSMC_PAT_ALL_OFF;
            `SSMC_FSI_ALL_OFF:  fs_pattern = `SSMC_PAT_ALL_OFF;
            `SSMC_FSI_OUT0:     fs_pattern = `SSMC_PAT_OUT0;
            `SSMC_FSI_OPEN:     fs_pattern = `SSMC_PAT_OUT0_OUT2;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_next = r_reg;

        // pin synchronisers
        r_next.wake_s = {r_reg.wake_s[0], i_wake};
        r_next.rstp_s = {r_reg.rstp_s[0], i_reset_pin_n};
        r_next.fsi_s0 = {r_reg.fsi_s0[1:0], i_failsafe_select_input};
        r_next.fsi_s1 = r_reg.fsi_s0[3:2];
        r_next.flt_s0 = i_fault_cond;
        r_next.flt_s1 = r_reg.flt_s0;

        wake      = r_reg.wake_s[1];
        rstp      = r_reg.rstp_s[1];
        failsafe_select_input       = r_reg.fsi_s1;
        fault_now = r_reg.flt_s1;
        fsi_gnd   = (failsafe_select_input == `SSMC_FSI_GROUNDED);
        rst_rise  = rstp & ~r_reg.rstp_d;
        wake_rise = wake & ~r_reg.wake_d;
        both_fall = r_reg.wake_d & r_reg.rstp_d & ~wake & ~rstp;
        r_next.wake_d = wake;
        r_next.rstp_d = rstp;

        cmd_addr = bus.rx_word[`SSMC_ADDR_MSB:`SSMC_ADDR_LSB];
        cmd_data = bus.rx_word[7:0];
        cmd_ka   = bus.rx_word[`SSMC_KEEPALIVE_BIT];

        // command commit
        if (bus.cs_rise) begin
            unique case (cmd_addr)
                `SSMC_ADDR_OUT_CTRL: r_next.out_cmd = cmd_data[3:0];
                `SSMC_ADDR_WD_CFG:   r_next.wd_sel  = cmd_data[1:0];
                default: ;
            endcase
        end

        // fault latch, cleared by the transfer that reported it; a new fault wins
        if (bus.cs_fall) begin
            r_next.fault_lat = fault_now;
        end else begin
            r_next.fault_lat = r_reg.fault_lat | fault_now;
        end

        // watchdog
        if (fsi_gnd) begin
            r_next.wd_run = 1'b0;
            r_next.wd_cnt = '0;
            r_next.wd_exp = 1'b0;
        end else if (rst_rise || wake_rise) begin
            r_next.wd_run = 1'b1;
            r_next.wd_cnt = '0;
        end else if (bus.cs_rise && (cmd_ka != r_reg.last_ka)) begin
            r_next.wd_cnt = '0;
        end else if (r_reg.wd_run && r_reg.mode != ssmc_pkg::SSMC_SLEEP) begin
            if (r_reg.wd_cnt >= wd_limit - 32'h00000001) begin
                r_next.wd_exp = 1'b1;
                r_next.wd_run = 1'b0;
            end else begin
                r_next.wd_cnt = r_reg.wd_cnt + 32'h00000001;
            end
        end
        if (bus.cs_rise) begin
            r_next.last_ka = cmd_ka;
        end

        // reset pin low clears configuration and faults
        if (!rstp) begin
            r_next.out_cmd   = '0;
            r_next.wd_sel    = '0;
            r_next.fault_lat = fault_now;
        end

        // operating mode
        unique case (r_reg.mode)
            ssmc_pkg::SSMC_FAILSAFE: begin
                if (both_fall) begin
                    r_next.mode   = ssmc_pkg::SSMC_SLEEP;
                    r_next.wd_exp = 1'b0;
                end else if (fsi_gnd) begin
                    r_next.mode = pick_mode(wake, rstp, 1'b0, fault_now);
                end
            end
            ssmc_pkg::SSMC_SLEEP,
            ssmc_pkg::SSMC_NORMAL,
            ssmc_pkg::SSMC_FAULT: begin
                r_next.mode = pick_mode(wake, rstp, r_next.wd_exp, fault_now);
            end
        endcase

        // power outputs
        unique case (r_next.mode)
            ssmc_pkg::SSMC_SLEEP:    r_next.power_out = '0;
            ssmc_pkg::SSMC_FAILSAFE: r_next.power_out = fs_pattern;
            ssmc_pkg::SSMC_NORMAL,
            ssmc_pkg::SSMC_FAULT: begin
                r_next.power_out = r_next.out_cmd & ~r_next.fault_lat & ~fault_now;
            end
        endcase

        r_next.fault_oe = |fault_now;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers; power-up lands in sleep with all settings zero

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            r_reg <= '0;
        end else if (i_ce) begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_so               = bus.so;
    assign o_so_oe            = bus.so_oe;
    assign o_fault_flag_n_o   = 1'b0;
    assign o_fault_flag_n_oe  = r_reg.fault_oe;
    assign o_power_output     = r_reg.power_out;
    assign o_mode             = r_reg.mode;
    assign o_watchdog_expired = r_reg.wd_exp;

endmodule : ssmc_top

// [inc/ssmc_defines.svh]
// constants of the serial switch mode controller
//
// Operation
// - fault flag pin pulled low while any fault is present, released otherwise.
// - reset pin low clears configuration and fault registers; sleep may follow.
// - watchdog timer starts on the low-to-high edge of the wake pin or the reset pin.
// - chip select high ignores clock and data; serial output driven only when selected.
// - chip select rise commits the received word to the addressed register.
// - chip select fall loads current status into the transmit shifter.
// - input sampled on clock fall; next output bit shifted on clock rise.
// - every transfer is sixteen bits, most significant first, both directions.
// - a five-bit address field selects the target register.
// - word out is first sixteen status bits; word in is newest command.
// - status word reports outputs, configuration and key input levels.
// - watchdog timeout applies fail-safe pattern chosen by fail-safe select level.
// - fail-safe select grounded disables watchdog and fail-safe operation.
// - exactly four modes: sleep, normal, fault and fail-safe.
// - wake and reset both low means sleep with all outputs off, except in fail-safe.
// - power-up is sleep with every configurable setting zero.
// - reset high, no fault, no timeout gives normal with fault flag high.
// - fault mode drives fault flag low and keeps faulted outputs off.
// - fail-safe left only by joint wake/reset fall or grounded select.
// - host toggles keepalive bit in time, else device enters fail-safe.
// - status bit 2 reads one while in fail-safe.
`ifndef SSMC_DEFINES_SVH
`define SSMC_DEFINES_SVH

`define SSMC_WORD_W          16
`define SSMC_KEEPALIVE_BIT   15
`define SSMC_ADDR_MSB        12
`define SSMC_ADDR_LSB        8
`define SSMC_ADDR_OUT_CTRL   5'h01
`define SSMC_ADDR_WD_CFG     5'h02

`define SSMC_FSI_GROUNDED    2'h0
`define SSMC_FSI_ALL_OFF     2'h1
`define SSMC_FSI_OUT0        2'h2
`define SSMC_FSI_OPEN        2'h3
`define SSMC_PAT_ALL_OFF     4'h0
`define SSMC_PAT_OUT0        4'h1
`define SSMC_PAT_OUT0_OUT2   4'h5

`define SSMC_WD_SEL_BASE     2'h0
`define SSMC_WD_SEL_HALF     2'h1
`define SSMC_WD_SEL_QUAD     2'h2
`define SSMC_WD_SEL_DOUBLE   2'h3

`define SSMC_ST_FAILSAFE_BIT 2

`define SSMC_CLK_KHZ         125000
`define SSMC_WDTO0_MS        558
`define SSMC_WDTO0_CYC       (`SSMC_WDTO0_MS * `SSMC_CLK_KHZ)

`endif

// [inc/ssmc_pkg.sv]
// types of the serial switch mode controller
package ssmc_pkg;

    typedef enum logic [1:0] {
        SSMC_SLEEP    = 2'b00,
        SSMC_NORMAL   = 2'b01,
        SSMC_FAULT    = 2'b10,
        SSMC_FAILSAFE = 2'b11
    } ssmc_mode_e;

    typedef struct packed {
        logic [1:0]  cs_s;
        logic [1:0]  sclk_s;
        logic [1:0]  si_s;
        logic        cs_d;
        logic        sclk_d;
        logic [15:0] rx;
        logic [15:0] tx;
        logic        so;
        logic        so_oe;
        logic        cs_rise;
        logic        cs_fall;
    } ssmc_shift_s;

    typedef struct packed {
        logic [1:0]  wake_s;
        logic [1:0]  rstp_s;
        logic [3:0]  fsi_s0;
        logic [1:0]  fsi_s1;
        logic [3:0]  flt_s0;
        logic [3:0]  flt_s1;
        logic        wake_d;
        logic        rstp_d;
        ssmc_mode_e  mode;
        logic [3:0]  out_cmd;
        logic [1:0]  wd_sel;
        logic [3:0]  fault_lat;
        logic [31:0] wd_cnt;
        logic        wd_run;
        logic        last_ka;
        logic        wd_exp;
        logic [3:0]  power_out;
        logic        fault_oe;
    } ssmc_ctrl_s;

endpackage : ssmc_pkg

// [inc/ssmc_spi_if.sv]
// link between the serial shifter and the mode controller
`timescale 1ns/1ps
interface ssmc_spi_if;
    logic        cs_rise;
    logic        cs_fall;
    logic [15:0] rx_word;
    logic [15:0] tx_word;
    logic        so;
    logic        so_oe;

    modport shifter (
        output cs_rise,
        output cs_fall,
        output rx_word,
        output so,
        output so_oe,
        input  tx_word
    );

    modport ctrl (
        input  cs_rise,
        input  cs_fall,
        input  rx_word,
        input  so,
        input  so_oe,
        output tx_word
    );
endinterface : ssmc_spi_if

// [tb/ssmc_host_model.sv]
// host serial master on the select, clock and data pins
`timescale 1ns/1ps
module ssmc_host_model (
    input  wire logic i_clk,
    input  wire logic i_so,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_si
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si   = 1'b0;
    end
    ////////////////////////////////////////////////////////////////
    task automatic xfer(input logic [15:0] w, input int h, output logic [15:0] r);
        o_cs_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (h) @(posedge i_clk);
            r[i] = i_so;
            o_sclk <= 1'b1;
            o_si   <= w[i];
            repeat (h) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        repeat (h) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_si   <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask : xfer
endmodule : ssmc_host_model

// [tb/ssmc_props.sv]
// port assertions of the mode controller
`timescale 1ns/1ps
module ssmc_props (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_cs_n,
    input wire logic       i_wake,
    input wire logic       i_reset_pin_n,
    input wire logic [1:0] i_failsafe_select_input,
    input wire logic [3:0] i_fault_cond,
    input wire logic       o_so_oe,
    input wire logic       o_fault_flag_n_o,
    input wire logic       o_fault_flag_n_oe,
    input wire logic [3:0] o_power_output,
    input wire logic [1:0] o_mode,
    input wire logic       o_watchdog_expired
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////
    flag_drive_low_a: assert property (o_fault_flag_n_o == 1'b0)
        else $error("flag drive value not low");
    flag_on_fault_a: assert property ((i_fault_cond != 4'h0) [*6] |-> o_fault_flag_n_oe)
        else $error("flag not pulled on fault");
    flag_released_a: assert property ((i_fault_cond == 4'h0) [*6] |-> !o_fault_flag_n_oe)
        else $error("flag held without fault");
    so_idle_a: assert property (i_cs_n [*6] |-> !o_so_oe)
        else $error("serial out driven while idle");
    so_drive_a: assert property (!i_cs_n [*6] |-> o_so_oe)
        else $error("serial out not driven while selected");
    sleep_off_a: assert property ((!i_wake && !i_reset_pin_n && o_mode != 2'h3) [*6]
        |-> o_mode == 2'h0 && o_power_output == 4'h0)
        else $error("not asleep with pins low");
    faulted_off_a: assert property (($stable(i_fault_cond) && o_mode != 2'h3) [*6]
        |-> (o_power_output & i_fault_cond) == 4'h0)
        else $error("faulted output on");
    fs_status_a: assert property (o_mode == 2'h3 |-> o_watchdog_expired)
        else $error("fail-safe without expiry");
    fs_pattern_a: assert property ((o_mode == 2'h3 && i_failsafe_select_input != 2'h0
        && $stable(i_failsafe_select_input)) [*5] |-> o_power_output ==
        (i_failsafe_select_input == 2'h1 ? 4'h0 : i_failsafe_select_input == 2'h2 ? 4'h1 : 4'h5))
        else $error("wrong fail-safe pattern");
    grounded_off_a: assert property ((i_failsafe_select_input == 2'h0) [*6] |-> o_mode != 2'h3)
        else $error("fail-safe while grounded");
    expiry_fs_a: assert property ($rose(o_watchdog_expired) |-> ##[0:3] o_mode == 2'h3)
        else $error("expiry without fail-safe");
    fs_held_a: assert property (o_mode == 2'h3 && i_wake && i_reset_pin_n
        && i_failsafe_select_input != 2'h0 |=> o_mode == 2'h3)
        else $error("fail-safe left early");
endmodule : ssmc_props
bind ssmc_top ssmc_props ssmc_props_inst (
    .i_sys_clk               (i_sys_clk),
    .i_rst_n                 (i_rst_n),
    .i_cs_n                  (i_cs_n),
    .i_wake                  (i_wake),
    .i_reset_pin_n           (i_reset_pin_n),
    .i_failsafe_select_input (i_failsafe_select_input),
    .i_fault_cond            (i_fault_cond),
    .o_so_oe                 (o_so_oe),
    .o_fault_flag_n_o        (o_fault_flag_n_o),
    .o_fault_flag_n_oe       (o_fault_flag_n_oe),
    .o_power_output          (o_power_output),
    .o_mode                  (o_mode),
    .o_watchdog_expired      (o_watchdog_expired)
);

// [tb/switch_spi_mode_control_test.sv]
// self-checking bench of the mode controller
`timescale 1ns/1ps
module switch_spi_mode_control_test;
    localparam int WD = 600;
    logic        i_sys_clk, i_rst_n, i_wake, i_reset_pin_n, ka;
    logic        cs_n, sclk, si, so, so_oe, flag_o, flag_oe, wd_exp;
    logic [1:0]  failsafe_select_input, mode;
    logic [3:0]  fault, pow, pat, f;
    int          err_total, n_compared, cyc, cmd, sel, lat, fs;
    ////////////////////////////////////////////////////////////////
    ssmc_top #(.WD_BASE_CYC(32'(WD))) ssmc_top_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_ce(1'b1), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si), .i_wake(i_wake),
        .i_reset_pin_n(i_reset_pin_n), .i_failsafe_select_input(failsafe_select_input), .i_fault_cond(fault),
        .o_so(so), .o_so_oe(so_oe), .o_fault_flag_n_o(flag_o), .o_fault_flag_n_oe(flag_oe),
        .o_power_output(pow), .o_mode(mode), .o_watchdog_expired(wd_exp));
    ssmc_host_model ssmc_host_model_inst (.i_clk(i_sys_clk), .i_so(so), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_si(si));
    ////////////////////////////////////////////////////////////////
    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : wt
    function automatic logic [3:0] pw();
        return fs ? pat : 4'(cmd & ~lat);
    endfunction : pw
    task automatic txn(input int a, input int d, input int h);
        logic [15:0] w, r, e;
        ka = ~ka;
        w = {ka, 2'h0, 5'(a), 8'(d)};
        e = {4'(lat), pw(), failsafe_select_input, i_wake, i_reset_pin_n, 1'(fs == 0), 1'(fs), 2'(sel)};
        ssmc_host_model_inst.xfer(w, h, r);
        lat = fault;
        if (i_reset_pin_n && a == 1) cmd = d % 16;
        if (i_reset_pin_n && a == 2) sel = d % 4;
        wt(6);
        chk(r, e);
        chk(16'(pow), 16'(pw()));
    endtask : txn
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h56EED860));
        {i_rst_n, i_wake, i_reset_pin_n, fault, ka, cmd, sel, lat, fs} = '0;
        failsafe_select_input = 2'h3;
        wt(10);
        i_rst_n <= 1'b1;
        wt(4);
        chk(16'({mode, pow}), 16'h0);
        i_reset_pin_n <= 1'b1;
        wt(8);
        chk(16'({mode, flag_oe}), 16'h2);
        repeat (8) txn($urandom % 4, $urandom % 256, 5);
        txn(1, 8'hFF, 5);
        txn(2, 8'h03, 5);
        txn(31, 8'h00, 5);
        f = 4'(1 + $urandom % 15);
        fault <= f;
        lat = lat | f;
        wt(8);
        chk(16'({mode, flag_oe, pow}), 16'({2'h2, 1'b1, ~f}));
        txn(31, 0, 5);
        fault <= 4'h0;
        wt(8);
        chk(16'(flag_oe), 16'h0);
        txn(31, 0, 5);
        txn(31, 0, 5);
        i_wake <= 1'b1;
        i_reset_pin_n <= 1'b0;
        wt(8);
        {cmd, sel, lat} = '0;
        txn(1, 8'hFF, 5);
        for (int c = 1; c < 4; c++) begin
            {i_wake, i_reset_pin_n} <= 2'h0;
            failsafe_select_input <= 2'(c);
            wt(8);
            chk(16'(mode), 16'h0);
            i_wake <= (c != 2);
            i_reset_pin_n <= 1'b1;
            wt(WD - 40);
            chk(16'(wd_exp), 16'h0);
            wt(80);
            pat = c == 1 ? 4'h0 : c == 2 ? 4'h1 : 4'h5;
            fs = 1;
            chk(16'({mode, pow}), 16'({2'h3, pat}));
            txn(31, 0, 5);
            if (c == 2) begin
                i_reset_pin_n <= 1'b0;
                wt(8);
                chk(16'(mode), 16'h3);
                failsafe_select_input <= 2'h0;
                wt(4);
                failsafe_select_input <= 2'h2;
                wt(8);
            end else begin
                {i_wake, i_reset_pin_n} <= 2'h0;
                wt(8);
            end
            chk(16'(mode), 16'h0);
            fs = 0;
        end
        failsafe_select_input <= 2'h0;
        {i_wake, i_reset_pin_n} <= 2'h3;
        wt(WD + 80);
        chk(16'({mode, wd_exp}), 16'h2);
        wrap_up();
    end
endmodule : switch_spi_mode_control_test
